//--- src/exposure_sequence_trigger.sv
// Exposure sequencer: entry table, trigger qualification and step control
//
// Notes on behaviour
// - Start trigger from software or external source
// - Entry count programmable from 0 to 255
// - Each entry holds own exposure and gain
// - One exposure per entry, in order, per trigger
// - Always-software setting accepts software as well as the selected source
// - Triggers ignored while trigger-wait is low
`timescale 1ns/1ps
`default_nettype none
module exposure_sequence_trigger
  import exposure_seq_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Configuration
  input  wire logic                seq_mode_en,
  input  wire trig_src_e           trig_src,
  input  wire logic                always_soft_trig,
  input  wire logic [ENTRY_W-1:0]  entry_count,
  // Entry table access
  input  wire tbl_wr_s             tbl_wr,
  input  wire logic [ENTRY_W-1:0]  rd_idx,
  output seq_entry_s               rd_entry,
  // Trigger sources
  input  wire logic                soft_trig,
  input  wire logic                ext_trig_pin,
  // Sensor exposure control
  input  wire logic                readout_done,
  output logic                     exp_start,
  output logic                     exposing,
  output seq_entry_s               exp_entry,
  // Status
  output logic                     trig_wait,
  output logic [ENTRY_W-1:0]       entry_index,
  output logic                     trig_ignored,
  output logic                     seq_done
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXPOSE,
    ST_READOUT
  } seq_state_e;

  seq_state_e          state;
  seq_entry_s          table_q [TABLE_SIZE];
  logic [ENTRY_W-1:0]  count_q;
  logic [EXP_W-1:0]    us_left;
  logic [UNIT_CNT_W-1:0] unit_cnt;
  logic                ext_rise;
  logic                soft_ok;
  logic                ext_ok;
  logic                any_trig;
  logic                accept;
  logic                exp_end;
  logic                last_entry;
  logic [ENTRY_W-1:0]  next_index;

  // Step an entry index by one
  function automatic logic [ENTRY_W-1:0] step_index(
    input logic [ENTRY_W-1:0] idx
  );
    step_index = idx + INDEX_STEP;
  endfunction : step_index

  // External line is asynchronous to ref_clk
  trigger_line_sync u_ext_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .line_in   (ext_trig_pin),
    .line_rise (ext_rise)
  );

  // entry count register
  // Latched from the port so a change mid-sequence cannot skip the end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= COUNT_RST;
    end else if (state == ST_IDLE) begin
      count_q <= entry_count;
    end
  end

  // per-entry storage
  // Entries are written individually; only the addressed one changes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < TABLE_SIZE; i++) begin
        table_q[i] <= ENTRY_RST;
      end
    end else if (tbl_wr.wr) begin
      table_q[tbl_wr.idx] <= tbl_wr.entry;
    end
  end

  // Registered read-back of one entry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_entry <= ENTRY_RST;
    end else begin
      rd_entry <= table_q[rd_idx];
    end
  end

  // software accepted as well when always-on is set
  always_comb begin
    soft_ok  = soft_trig & ((trig_src == TRIG_SRC_SOFT) | always_soft_trig);
    ext_ok   = ext_rise & (trig_src == TRIG_SRC_EXT);
    any_trig = soft_ok | ext_ok;
  end

  // accept only while waiting
  // An empty sequence never leaves idle, so its triggers do nothing
  assign accept = any_trig & seq_mode_en & (state == ST_IDLE)
                  & (count_q != COUNT_RST);

  // Exposure ends once the remaining time has run down
  assign exp_end    = (state == ST_EXPOSE) & (us_left == EXP_RST);
  assign last_entry = (step_index(entry_index) == count_q);
  assign next_index = step_index(entry_index);

  // return to idle after the last entry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          if (exp_end) begin
            state <= ST_READOUT;
          end
        end
        ST_READOUT: begin
          if (readout_done) begin
            state <= last_entry ? ST_IDLE : ST_EXPOSE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entry_index <= INDEX_RST;
    end else if (accept) begin
      entry_index <= INDEX_RST;
    end else if ((state == ST_READOUT) && readout_done && !last_entry) begin
      entry_index <= next_index;
    end
  end

  // apply the entry's exposure and gain
  // The entry is captured at start, so table writes cannot disturb it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exp_entry <= ENTRY_RST;
    end else if (accept) begin
      exp_entry <= table_q[INDEX_RST];
    end else if ((state == ST_READOUT) && readout_done && !last_entry) begin
      exp_entry <= table_q[next_index];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      us_left  <= EXP_RST;
      unit_cnt <= UNIT_RST;
    end else if (accept) begin
      us_left  <= table_q[INDEX_RST].exp_us;
      unit_cnt <= UNIT_RST;
    end else if ((state == ST_READOUT) && readout_done && !last_entry) begin
      us_left  <= table_q[next_index].exp_us;
      unit_cnt <= UNIT_RST;
    end else if ((state == ST_EXPOSE) && (us_left != EXP_RST)) begin
      if (unit_cnt == UNIT_LAST) begin
        unit_cnt <= UNIT_RST;
        us_left  <= us_left - EXP_STEP;
      end else begin
        unit_cnt <= unit_cnt + UNIT_STEP;
      end
    end
  end

  // Exposure start pulse and active level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exp_start <= 1'b0;
      exposing  <= 1'b0;
    end else begin
      exp_start <= accept
                   | ((state == ST_READOUT) & readout_done & ~last_entry);
      if (accept) begin
        exposing <= 1'b1;
      end else if ((state == ST_READOUT) && readout_done && !last_entry) begin
        exposing <= 1'b1;
      end else if (exp_end) begin
        exposing <= 1'b0;
      end
    end
  end

  // trigger-wait indication
  // Low from exposure start until the final readout completes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_wait <= 1'b1;
    end else if (accept) begin
      trig_wait <= 1'b0;
    end else if ((state == ST_READOUT) && readout_done && last_entry) begin
      trig_wait <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_ignored <= 1'b0;
    end else begin
      trig_ignored <= any_trig & seq_mode_en & (state != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_done <= 1'b0;
    end else begin
      seq_done <= (state == ST_READOUT) & readout_done & last_entry;
    end
  end

endmodule : exposure_sequence_trigger
`default_nettype wire

//--- src/exposure_seq_pkg.sv
// Constants, carrier types and timing for the exposure sequence trigger
package exposure_seq_pkg;

  // Clock and exposure time base
  localparam int CLK_HZ      = 50_000_000;
  localparam int EXP_UNIT_NS = 1000;
  localparam int UNIT_CYCLES = (EXP_UNIT_NS * (CLK_HZ / 1_000_000) + 999)
                               / 1000;

  // Field widths
  localparam int ENTRY_W    = 8;
  localparam int EXP_W      = 24;
  localparam int GAIN_W     = 16;
  localparam int UNIT_CNT_W = 6;
  localparam int TABLE_SIZE = 256;

  // Reset values and fixed counts
  localparam logic [ENTRY_W-1:0]    COUNT_RST  = 8'h00;
  localparam logic [ENTRY_W-1:0]    INDEX_RST  = 8'h00;
  localparam logic [ENTRY_W-1:0]    INDEX_STEP = 8'h01;
  localparam logic [EXP_W-1:0]      EXP_RST    = 24'h000000;
  localparam logic [EXP_W-1:0]      EXP_STEP   = 24'h000001;
  localparam logic [GAIN_W-1:0]     GAIN_RST   = 16'h0000;
  localparam logic [UNIT_CNT_W-1:0] UNIT_RST   = 6'h00;
  localparam logic [UNIT_CNT_W-1:0] UNIT_STEP  = 6'h01;
  localparam logic [UNIT_CNT_W-1:0] UNIT_LAST  =
    UNIT_CNT_W'(UNIT_CYCLES - 1);

  // Trigger source selection
  typedef enum logic {
    TRIG_SRC_SOFT,
    TRIG_SRC_EXT
  } trig_src_e;

  // One sequence entry
  typedef struct packed {
    logic [EXP_W-1:0]  exp_us;
    logic [GAIN_W-1:0] gain;
  } seq_entry_s;

  // Table write request
  typedef struct packed {
    logic               wr;
    logic [ENTRY_W-1:0] idx;
    seq_entry_s         entry;
  } tbl_wr_s;

  localparam seq_entry_s ENTRY_RST = '{exp_us: EXP_RST, gain: GAIN_RST};

endpackage : exposure_seq_pkg

//--- src/trigger_line_sync.sv
// Synchroniser and rising-edge detector for the external trigger line
`timescale 1ns/1ps
`default_nettype none
module trigger_line_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Raw pin and detected edge
  input  wire logic line_in,
  output logic      line_rise
);

  logic meta;
  logic stable;
  logic stable_d;

  // Two flops before any logic looks at the pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
    end else begin
      meta   <= line_in;
      stable <= meta;
    end
  end

  // Edge detector reads only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stable_d  <= 1'b0;
      line_rise <= 1'b0;
    end else begin
      stable_d  <= stable;
      line_rise <= stable & ~stable_d;
    end
  end

endmodule : trigger_line_sync
`default_nettype wire

//--- tb/exposure_sequence_trigger_checker.sv
// Port assertions for the exposure sequencer
`timescale 1ns/1ps
`default_nettype none
module exposure_sequence_trigger_checker
  import exposure_seq_pkg::*;
(
  // Block inputs
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               seq_mode_en,
  input wire trig_src_e          trig_src,
  input wire logic               always_soft_trig,
  input wire logic [ENTRY_W-1:0] entry_count,
  input wire logic               soft_trig,
  input wire logic               readout_done,
  // Block outputs
  input wire logic               exp_start,
  input wire logic               exposing,
  input wire seq_entry_s         exp_entry,
  input wire logic               trig_wait,
  input wire logic [ENTRY_W-1:0] entry_index,
  input wire logic               trig_ignored,
  input wire logic               seq_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] cnt;
  logic        soft_ok;
  // Software trigger that the source settings allow
  assign soft_ok = seq_mode_en && soft_trig &&
                   (trig_src == TRIG_SRC_SOFT || always_soft_trig);
  // Length of the running exposure in cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt <= 32'h0;
    else if (exp_start) cnt <= 32'h1;
    else if (exposing) cnt <= cnt + 32'h1;
  end
  // Count latched last idle cycle, so the start is certain
  AST_SOFT_START:
    assert property (soft_ok && trig_wait && $past(trig_wait) && !$past(rst)
      && $past(entry_count) != 8'h00 |=> exp_start && entry_index == INDEX_RST)
    else $error("soft trigger did not start entry 0");
  AST_IGNORE:
    assert property (soft_ok && !trig_wait |=> trig_ignored)
    else $error("busy trigger not flagged");
  AST_MODE_OFF:
    assert property (!seq_mode_en && trig_wait |=> !exp_start && !trig_ignored)
    else $error("activity with sequence mode off");
  AST_EXP_LEN:
    assert property ($fell(exposing) |->
      cnt == $past(exp_entry.exp_us) * UNIT_CYCLES + 1)
    else $error("exposure length wrong");
  AST_ENTRY_HOLD:
    assert property (exposing && !exp_start |-> $stable(exp_entry))
    else $error("entry changed during exposure");
  AST_STEP:
    assert property (readout_done && !trig_wait && !exposing |=>
      (exp_start && entry_index == $past(entry_index) + INDEX_STEP)
      || (seq_done && trig_wait))
    else $error("no step after readout");
  AST_DONE_IDLE:
    assert property (seq_done |-> trig_wait && !exposing)
    else $error("done while busy");
  AST_START_BUSY:
    assert property (exp_start |-> exposing && !trig_wait)
    else $error("wait high at exposure start");
  C_IGN: cover property (trig_ignored);
  C_DONE: cover property (seq_done);
  C_BOTH: cover property (always_soft_trig && trig_src == TRIG_SRC_EXT
                          && exp_start);
endmodule : exposure_sequence_trigger_checker
bind exposure_sequence_trigger exposure_sequence_trigger_checker chk_u (
  .ref_clk, .rst, .seq_mode_en, .trig_src, .always_soft_trig, .entry_count,
  .soft_trig, .readout_done, .exp_start, .exposing, .exp_entry, .trig_wait,
  .entry_index, .trig_ignored, .seq_done);
`default_nettype wire

//--- tb/sensor_side_model.sv
// Trigger line and sensor readout model on the far side
`timescale 1ns/1ps
`default_nettype none
module sensor_side_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Bench controls
  input  wire logic slow,
  input  wire logic fire,
  // Block side
  input  wire logic exposing,
  output logic      readout_done,
  output logic      ext_trig_pin
);
  logic [3:0] wait_cnt;
  logic [2:0] hi_cnt;
  logic       was_exp;
  // Readout ends two or ten cycles after the exposure ends
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 4'h0;
      readout_done <= 1'b0;
      was_exp <= 1'b0;
    end else begin
      readout_done <= 1'b0;
      was_exp <= exposing;
      if (was_exp && !exposing) wait_cnt <= slow ? 4'h9 : 4'h1;
      else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
        readout_done <= (wait_cnt == 4'h1);
      end
    end
  end
  // Pin held high four cycles so the synchroniser cannot miss it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) hi_cnt <= 3'h0;
    else if (fire) hi_cnt <= 3'h4;
    else if (hi_cnt != 3'h0) hi_cnt <= hi_cnt - 3'h1;
  end
  assign ext_trig_pin = (hi_cnt != 3'h0);
endmodule : sensor_side_model
`default_nettype wire

//--- tb/exposure_sequence_trigger_tb_top.sv
// Self-checking bench for the exposure sequencer
`timescale 1ns/1ps
`default_nettype none
module exposure_sequence_trigger_tb_top
  import exposure_seq_pkg::*;
;
  typedef struct packed {
    seq_entry_s         entry;
    logic [ENTRY_W-1:0] idx;
  } note_s;
  logic       ref_clk = 1'b0, rst = 1'b1, seq_mode_en = 1'b0;
  logic       always_soft_trig = 1'b0, soft_trig = 1'b0;
  logic       slow = 1'b0, fire = 1'b0, readout_done, ext_trig_pin;
  logic       exp_start, exposing, trig_wait, trig_ignored, seq_done;
  logic [7:0] entry_count = 8'h00, rd_idx = 8'h00, entry_index;
  trig_src_e  trig_src = TRIG_SRC_SOFT;
  tbl_wr_s    tbl_wr = '0;
  seq_entry_s rd_entry, exp_entry, tbl[TABLE_SIZE];
  note_s      notes[$], note;
  int         miscompares = 0, comparisons = 0, seed = 91047;
  int         ignored = 0, ign_exp = 0;
  // Per test: mode, source, always, slow, external, poke
  logic [5:0] cfg[10] = '{6'h00, 6'h20, 6'h21, 6'h20, 6'h30, 6'h36,
                          6'h38, 6'h3a, 6'h22, 6'h20};
  logic [7:0] n_tab[10] = '{8'h03, 8'h00, 8'h03, 8'h02, 8'h03, 8'h04,
                            8'h03, 8'h02, 8'h03, 8'hff};

  always #10 ref_clk = ~ref_clk;

  exposure_sequence_trigger dut_u (.ref_clk, .rst, .seq_mode_en, .trig_src,
    .always_soft_trig, .entry_count, .tbl_wr, .rd_idx, .rd_entry, .soft_trig,
    .ext_trig_pin, .readout_done, .exp_start, .exposing, .exp_entry,
    .trig_wait, .entry_index, .trig_ignored, .seq_done);
  sensor_side_model model_u (.ref_clk, .rst, .slow, .fire, .exposing,
    .readout_done, .ext_trig_pin);

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Notes expectations, triggers, waits for the end of the run
  task automatic run_seq(input logic [7:0] n, input logic ext,
                         input logic poke);
    int   k;
    logic go;
    @(posedge ref_clk);
    entry_count <= n;
    @(posedge ref_clk);
    go = seq_mode_en && n != 8'h00 && (ext ? trig_src == TRIG_SRC_EXT
         : trig_src == TRIG_SRC_SOFT || always_soft_trig);
    for (k = 0; go && k < n; k++) notes.push_back(note_s'{tbl[k], 8'(k)});
    fire <= ext;
    soft_trig <= !ext;
    @(posedge ref_clk);
    fire <= 1'b0;
    for (k = 0; k < (go ? 20000 : 20) && seq_done !== 1'b1; k++) begin
      soft_trig <= poke && k == 5;
      @(posedge ref_clk);
    end
    ign_exp += int'(poke);
    // done pulse seen exactly when a sequence ran; timeout shows as 0
    check(48'(seq_done === 1'b1), 48'(go));
    check(48'(notes.size()), 48'h0);
    check(48'(trig_wait), 48'h1);
    check(48'(ignored), 48'(ign_exp));
  endtask : run_seq

  // Each exposure start takes the oldest note
  always @(posedge ref_clk) begin
    if (exp_start === 1'b1) begin
      if (notes.size() == 0) check(48'h1, 48'h0);
      else begin
        note = notes.pop_front();
        check({exp_entry, entry_index}, note);
      end
    end
    if (trig_ignored === 1'b1) ignored++;
  end

  initial begin
    int i;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // random entries written and read back
    for (i = 0; i < TABLE_SIZE; i++) begin
      tbl[i] = '{24'($random(seed)) & 24'h1, 16'($random(seed))};
      tbl_wr <= '{1'b1, 8'(i), tbl[i]};
      @(posedge ref_clk);
    end
    tbl_wr.wr <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd_idx <= 8'(i * 60);
      repeat (2) @(posedge ref_clk);
      check(48'(rd_entry), 48'(tbl[i * 60]));
    end
    $display("test table done");
    for (i = 0; i < 10; i++) begin
      seq_mode_en <= cfg[i][5];
      trig_src <= trig_src_e'(cfg[i][4]);
      {always_soft_trig, slow} <= cfg[i][3:2];
      run_seq(n_tab[i], cfg[i][1], cfg[i][0]);
      $display("test %0d done", i);
    end
    tally_and_finish();
  end

  // Hang guard, far beyond the longest run
  initial begin
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : exposure_sequence_trigger_tb_top
`default_nettype wire
